// ### design/sme_master_top.sv
/*
  Serial master that reads a serial memory: frame engine, holding
  registers, status flags, receive buffer and a read sequencer.
  Assumes software polls the flags and the memory answers per mode.
*/
// Function
// R1 - Master drives clock; slave takes pin clock
// R2 - Serial clock 2.5 MHz from core clock
// R3 - Bit order, polarity, phase, rate selectable
// R4 - Separate serial data in and out pins
// R5 - Eight-bit frames, shift out and in together
// R6 - Transmit write clears transmit-empty flag
// R7 - Load shift register, set empty, start
// R8 - Frame end stores byte, sets receive-full
// R9 - Receive read clears receive-full flag
// R10 - Last bit with empty set sets end
// R11 - Transmit write clears empty and end
// R12 - End flag timing selectable, final bit; late timing works in master mode only
// R13 - Separate enables; both off stops transfer
// R14 - Host waits on full and empty flags
// R15 - Host finishes: read, deselect, clear, disable
// R16 - Memory select from general output, not per-frame
// R17 - Select low whole read, high after
// R18 - Read: instruction, address, then data bytes
// R19 - Read instruction byte is 0000 0011
// R20 - Write-enable, write-disable, write codes fixed
// R21 - Status read and write codes fixed
// R22 - Memory outputs bytes, advancing its address
// R23 - Example read covers ten bytes from zero
// R24 - Filler bytes keep clock running in data
`timescale 1ns/1ps
module sme_master_top
  import sme_pkg::*;
#(
  parameter int BYTE_COUNT = SME_READ_COUNT, // Data bytes per read
  parameter logic [15:0] START_ADDR = SME_START_ADDR,
  parameter int FIFO_DEPTH = 2, // Receive buffer entries
  parameter int FIFO_WIDTH = SME_FRAME_BITS
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire sme_mode_s mode_in,
  input wire logic tx_enable_bit_in,
  input wire logic rx_enable_bit_in,
  input wire logic [2:0] irq_enable_in,
  input wire logic tx_write_in,
  input wire logic [7:0] tx_data_in,
  input wire logic rx_read_in,
  output logic [FIFO_WIDTH-1:0] rx_data_out,
  input wire logic tx_end_clear_in,
  output sme_flags_s flags_out,
  output logic [2:0] event_req_out,
  input wire logic read_start_in,
  output logic seq_busy_out,
  output logic seq_done_out,
  input wire logic manual_select_in,
  output logic mem_select_gpio_out,
  output logic hw_chip_select_pin_n_out,
  output logic serial_out_pin_out,
  input wire logic serial_in_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_out,
  input wire logic serial_clock_pin_in
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [7:0] TOTAL = SME_HDR_BYTES + 8'(BYTE_COUNT);

  typedef enum logic [2:0] {
    FR_IDLE = 3'b001, FR_XFER = 3'b010, FR_END = 3'b100
  } sme_frame_e;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001, SQ_RUN = 3'b010, SQ_FIN = 3'b100
  } sme_seq_e;

  sme_frame_e fr_st; // Frame engine state
  sme_seq_e sq_st; // Read sequencer state
  logic [7:0] tx_hold_reg0; // Transmit holding register
  logic [7:0] serial_shift_reg; // Bits out, replaced by bits in
  logic tx_empty_flag, tx_end_flag, rx_full_flag;
  logic [5:0] div_cnt; // Half-period divider
  logic [5:0] div_lim; // Half period for the chosen rate
  logic [3:0] edge_cnt; // Clock edge within the frame
  logic sck_q; // Serial clock level driven out
  logic mosi_q; // Serial data level driven out
  logic [2:0] sck_sync, din_sync; // Pin synchronisers
  logic sck_lvl, din_lvl; // Settled pin levels
  logic m_tick, s_edge, tick; // Clock edge enables
  logic sample_edge; // Edge on which input is taken
  logic [2:0] drive_idx; // Next bit to put out
  logic cap_now, cap_late; // Input bit taken now, or half a period late
  logic [3:0] prev_edge; // Edge before the current one
  logic [2:0] cap_idx; // Bit number being taken
  logic [7:0] next_shift_reg; // Shift register with that bit in place
  logic start, frame_done, wr, any_en;
  logic seq_wr, seq_drop;
  logic [7:0] seq_byte, issued, done_cnt;
  logic [FIFO_WIDTH-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] fifo_cnt;
  logic push, pop, room;

  // Map a bit number to its place in the byte
  function automatic logic [2:0] sme_pos(input logic [2:0] i,
                                         input logic msb);
    return msb ? (3'h7 - i) : i; // see R3
  endfunction

  // ----------------------------------------------------------------
  // Clock generation and pin sampling
  // ----------------------------------------------------------------
  // Base half period shifted by the rate field
  assign div_lim = 6'(SME_HALF_CYC << mode_in.rate); // see R2, R3

  // Divider runs only during a frame, so each frame starts aligned
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_cnt <= 6'h00;
    end else if (fr_st == FR_IDLE || m_tick) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  assign m_tick = mode_in.master && (fr_st != FR_IDLE) &&
                  (div_cnt == div_lim - 6'h01); // see R1, R2

  // Three-stage synchronisers for clock and data pins
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sck_sync <= 3'h0;
      din_sync <= 3'h0;
    end else begin
      sck_sync <= {sck_sync[1:0], serial_clock_pin_in};
      din_sync <= {din_sync[1:0], serial_in_pin_in}; // see R4
    end
  end

  // A level counts only once second and third stages agree
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sck_lvl <= 1'b0;
      din_lvl <= 1'b0;
    end else begin
      if (sck_sync[1] == sck_sync[2]) begin
        sck_lvl <= sck_sync[2];
      end
      if (din_sync[1] == din_sync[2]) begin
        din_lvl <= din_sync[2];
      end
    end
  end

  assign s_edge = (sck_sync[1] == sck_sync[2]) && (sck_sync[2] != sck_lvl);
  // Slave mode follows the outside clock instead of the divider
  assign tick = mode_in.master ? m_tick :
                (s_edge && fr_st == FR_XFER); // see R1

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  assign any_en = tx_enable_bit_in | rx_enable_bit_in;
  assign wr = (sq_st == SQ_RUN) ? seq_wr : tx_write_in;
  // Full receive buffer stalls the next frame, so nothing is lost
  assign start = (fr_st == FR_IDLE) && !tx_empty_flag && any_en &&
                 (!rx_enable_bit_in || room); // see R7
  assign sample_edge = (edge_cnt[0] == mode_in.cpha); // see R3
  assign drive_idx = mode_in.cpha ? edge_cnt[3:1] :
                     (edge_cnt[3:1] + 3'h1);
  // Late mode in master waits one more half period after the last edge
  assign frame_done = (fr_st == FR_XFER && tick &&
                       edge_cnt == SME_LAST_EDGE &&
                       !(mode_in.tx_end_flag_late && mode_in.master)) ||
                      (fr_st == FR_END &&
                       (m_tick || !mode_in.master)); // see R12

  // Frame state and edge count
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fr_st <= FR_IDLE;
      edge_cnt <= 4'h0;
    end else if (!any_en) begin
      fr_st <= FR_IDLE; // Both enables off abort the frame; see R13
      edge_cnt <= 4'h0;
    end else begin
      case (fr_st)
        FR_IDLE: begin
          edge_cnt <= 4'h0;
          if (start) begin
            fr_st <= FR_XFER;
          end
        end
        FR_XFER: begin
          if (tick) begin
            edge_cnt <= edge_cnt + 4'h1; // Sixteen edges; see R5
            if (edge_cnt == SME_LAST_EDGE) begin
              fr_st <= frame_done ? FR_IDLE : FR_END;
            end
          end
        end
        FR_END: begin
          if (frame_done) begin
            fr_st <= FR_IDLE;
          end
        end
        default: begin
          fr_st <= FR_IDLE;
        end
      endcase
    end
  end

  // Input takes three cycles through the synchroniser, longer than the
  // fastest half period, so the master takes a bit half a period late
  // Limitation: non-late trailing-edge master needs rate above zero
  assign cap_now = fr_st == FR_XFER && tick && sample_edge &&
                   (!mode_in.master || (mode_in.cpha &&
                    !mode_in.tx_end_flag_late && edge_cnt == SME_LAST_EDGE));
  assign cap_late = mode_in.master && m_tick &&
                    ((fr_st == FR_XFER && !sample_edge &&
                      edge_cnt != 4'h0) ||
                     (fr_st == FR_END && mode_in.cpha)); // see R5
  assign prev_edge = edge_cnt - 4'h1;
  assign cap_idx = cap_now ? edge_cnt[3:1] : prev_edge[3:1];

  // Byte with this cycle's bit in place; also what a frame end pushes
  always_comb begin
    next_shift_reg = serial_shift_reg;
    if (cap_now || cap_late) begin
      next_shift_reg[sme_pos(cap_idx, mode_in.msb_first)] =
        mode_in.master ? din_sync[2] : din_lvl; // see R5
    end
  end

  // Shift register: load on start, else take the captured bit
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_shift_reg <= 8'h00;
    end else if (start) begin
      serial_shift_reg <= tx_hold_reg0; // see R7
    end else begin
      serial_shift_reg <= next_shift_reg;
    end
  end

  // Output bit changes only at start and on the drive edge, away from sampling
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mosi_q <= 1'b0;
    end else if (start) begin
      mosi_q <= tx_enable_bit_in &&
                tx_hold_reg0[sme_pos(3'h0, mode_in.msb_first)];
    end else if (fr_st == FR_XFER && tick && !sample_edge &&
                 edge_cnt != SME_LAST_EDGE) begin
      mosi_q <= tx_enable_bit_in &&
                serial_shift_reg[sme_pos(drive_idx,
                                         mode_in.msb_first)]; // see R5
    end
  end

  // Serial clock rests at the selected polarity between frames
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sck_q <= 1'b0;
    end else if (fr_st == FR_IDLE) begin
      sck_q <= mode_in.cpol; // see R3
    end else if (fr_st == FR_XFER && m_tick) begin
      sck_q <= ~sck_q; // see R1
    end
  end

  assign serial_clock_pin_out = sck_q;
  assign serial_clock_pin_oe_out = mode_in.master; // see R1
  assign serial_out_pin_out = mosi_q; // see R4
  // Pulses per frame, so unfit as the memory select
  assign hw_chip_select_pin_n_out = (fr_st == FR_IDLE); // see R16

  // ----------------------------------------------------------------
  // Transmit holding register and flags
  // ----------------------------------------------------------------
  // A write over a full hold replaces the pending byte
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_hold_reg0 <= 8'h00;
    end else if (wr) begin
      tx_hold_reg0 <= (sq_st == SQ_RUN) ? seq_byte : tx_data_in;
    end
  end

  // Write wins over load, since the new byte is still pending
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_empty_flag <= SME_TXE_RST;
    end else if (wr) begin
      tx_empty_flag <= 1'b0; // see R6, R11
    end else if (start) begin
      tx_empty_flag <= 1'b1; // see R7
    end
  end

  // End flag: hardware set beats a same-cycle clear
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_end_flag <= 1'b0;
    end else if (frame_done && tx_empty_flag) begin
      tx_end_flag <= 1'b1; // see R10, R12
    end else if (wr || tx_end_clear_in) begin
      tx_end_flag <= 1'b0; // see R11
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  assign room = (fifo_cnt != CW'(FIFO_DEPTH));
  assign push = frame_done && rx_enable_bit_in && !seq_drop && room;
  assign pop = rx_read_in && (fifo_cnt != '0); // see R9

  // Head entry doubles as the receive holding register
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fifo_cnt <= fifo_cnt + 1'b1; // see R8
      end else if (pop && !push) begin
        fifo_cnt <= fifo_cnt - 1'b1; // see R9
      end
    end
  end

  // Storage has no reset; only written entries are ever shown
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      fifo_mem[wr_ptr] <= FIFO_WIDTH'(next_shift_reg); // see R8
    end
  end

  assign rx_full_flag = (fifo_cnt != '0);
  assign rx_data_out = (fifo_cnt != '0) ? fifo_mem[rd_ptr] : '0;
  assign flags_out = '{tx_empty: tx_empty_flag, tx_end: tx_end_flag,
                       rx_full: rx_full_flag};
  // Each request has its own enable; no interrupt logic here
  assign event_req_out = {rx_full_flag, tx_end_flag, tx_empty_flag} &
                         irq_enable_in; // see R13

  // ----------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------
  // Header first, then filler that just keeps the clock going
  always_comb begin
    case (issued)
      8'h00: seq_byte = SME_CMD_READ; // see R18, R19
      8'h01: seq_byte = START_ADDR[15:8]; // see R23
      8'h02: seq_byte = START_ADDR[7:0];
      default: seq_byte = SME_FILLER; // see R24
    endcase
  end

  assign seq_wr = (sq_st == SQ_RUN) && tx_empty_flag && (issued != TOTAL);
  assign seq_drop = (sq_st == SQ_RUN) && (done_cnt < SME_HDR_BYTES);

  // Sequence state and byte counters
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sq_st <= SQ_IDLE;
      issued <= 8'h00;
      done_cnt <= 8'h00;
    end else begin
      case (sq_st)
        SQ_IDLE: begin
          issued <= 8'h00;
          done_cnt <= 8'h00;
          if (read_start_in) begin
            sq_st <= SQ_RUN; // see R18
          end
        end
        SQ_RUN: begin
          if (seq_wr) begin
            issued <= issued + 8'h01;
          end
          if (frame_done) begin
            done_cnt <= done_cnt + 8'h01;
          end
          if (done_cnt == TOTAL && fr_st == FR_IDLE) begin
            sq_st <= SQ_FIN;
          end
        end
        SQ_FIN: begin
          sq_st <= SQ_IDLE;
        end
        default: begin
          sq_st <= SQ_IDLE;
        end
      endcase
    end
  end

  // Select held low for the whole read, high once it is over
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_select_gpio_out <= SME_SEL_RST;
      seq_done_out <= 1'b0;
    end else begin
      mem_select_gpio_out <= !((sq_st == SQ_RUN) ||
                               manual_select_in); // see R16, R17
      seq_done_out <= (sq_st == SQ_FIN);
    end
  end

  assign seq_busy_out = (sq_st != SQ_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] tick_cnt; // Edges seen in the current frame
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt <= 5'h00;
    end else if (start) begin
      tick_cnt <= 5'h00;
    end else if (tick || (fr_st == FR_END && m_tick)) begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  AST_TXE_CLEAR: assert property (wr |=> !tx_empty_flag) // see R6
    else $error("write did not clear empty flag");
  AST_LOAD: assert property (start && !wr |=> tx_empty_flag &&
    serial_shift_reg == $past(tx_hold_reg0)) // see R7
    else $error("load did not move hold byte");
  AST_FRAME_LEN: assert property (frame_done && mode_in.master &&
    $stable(mode_in) |-> ##1 tick_cnt ==
    (mode_in.tx_end_flag_late ? 5'h11 : 5'h10)) // see R5
    else $error("frame edge count wrong");
  AST_RX_SET: assert property (push |=> rx_full_flag) // see R8
    else $error("frame end did not set receive full");
  AST_RX_CLR: assert property (pop && !push && fifo_cnt == CW'(1)
    |=> !rx_full_flag) // see R9
    else $error("read did not clear receive full");
  AST_TX_END_FLAG: assert property (frame_done && tx_empty_flag
    |=> tx_end_flag) // see R10
    else $error("end flag not set");
  AST_TX_END_FLAG_CLR: assert property (wr && !(frame_done && tx_empty_flag)
    |=> !tx_end_flag && !tx_empty_flag) // see R11
    else $error("write did not clear end flag");
  AST_STOP: assert property (!any_en |=> fr_st == FR_IDLE) // see R13
    else $error("transfer ran with both enables off");
  AST_SELECT: assert property ($rose(sq_st == SQ_RUN)
    |=> !mem_select_gpio_out) // see R17
    else $error("memory not selected at read start");
  AST_CMD: assert property (seq_wr && issued == 8'h00
    |=> tx_hold_reg0 == 8'h03) // see R19
    else $error("read instruction byte wrong");
  AST_STALL: assert property (frame_done && rx_enable_bit_in && // see R8
    !seq_drop |-> room)
    else $error("frame ended with receive buffer full");
endmodule // sme_master_top

// ### design/sme_pkg.sv
/*
  Shared constants and carrier types of the serial memory reader.
  Assumes a single 10 MHz core clock and an 8-bit serial memory.
*/
package sme_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SME_CORE_HZ = 10_000_000; // Core clock rate
  localparam int SME_SCK_HZ = 2_500_000; // Serial clock, 2.5 MHz
  // Half period in core cycles, rounded down, never below one
  localparam int SME_HALF_CYC = (SME_CORE_HZ / (2 * SME_SCK_HZ)) < 1 ?
    1 : (SME_CORE_HZ / (2 * SME_SCK_HZ));
  localparam int SME_FRAME_BITS = 8; // Bits per frame
  localparam logic [3:0] SME_LAST_EDGE = 4'hF; // Sixteenth clock edge

  // ----------------------------------------------------------------
  // Memory instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SME_CMD_READ = 8'h03;
  localparam logic [7:0] SME_CMD_WRITE = 8'h02;
  localparam logic [7:0] SME_MEM_WRITE_ENABLE_CMD = 8'h06; // see R20
  localparam logic [7:0] SME_MEM_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] SME_MEM_STATUS_GET_CMD = 8'h05; // see R21
  localparam logic [7:0] SME_MEM_STATUS_PUT_CMD = 8'h01;
  localparam logic [7:0] SME_FILLER = 8'hFF; // Ignored by memory

  // ----------------------------------------------------------------
  // Read sequence defaults
  // ----------------------------------------------------------------
  localparam logic [15:0] SME_START_ADDR = 16'h0000;
  localparam logic [15:0] SME_LAST_ADDR = 16'h0009;
  localparam int SME_READ_COUNT = int'(SME_LAST_ADDR - SME_START_ADDR) + 1;
  localparam logic [7:0] SME_HDR_BYTES = 8'h03; // Command, two address

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic SME_TXE_RST = 1'b1; // Transmit hold starts empty
  localparam logic SME_SEL_RST = 1'b1; // Memory deselected

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic master; // 1: drive serial clock, 0: take it from pin
    logic msb_first; // Bit order
    logic cpol; // Idle level of serial clock
    logic cpha; // 1: sample on trailing edge
    logic tx_end_flag_late; // 1: end flag after final bit time, master mode only
    logic [1:0] rate; // Half period = base shifted left by this
  } sme_mode_s;

  typedef struct packed {
    logic tx_empty;
    logic tx_end;
    logic rx_full;
  } sme_flags_s;
endpackage

// ### sim/sme_mem_model.sv
/*
  Behavioural serial memory on the far side of the reader.
  Assumes mode 0 framing, most significant bit first, active-low select.
*/
`timescale 1ns/1ps
module sme_mem_model (
  input wire logic sck_in,
  input wire logic sel_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic [7:0] cmd_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] rx = 8'h00; // Incoming bits
  logic [7:0] sh = 8'h00; // Outgoing byte
  logic [15:0] addr = 16'h0000; // Internal read pointer
  int cnt = 0; // Bits seen since select

  // New selection restarts the instruction decode
  always @(negedge sel_n_in) begin
    cnt = 0;
  end

  // Leading edge: take instruction, then address
  always @(posedge sck_in) begin
    if (!sel_n_in) begin
      rx = {rx[6:0], mosi_in};
      cnt++;
      if (cnt == 8) begin
        cmd_out = rx;
      end
      if (cnt > 8 && cnt <= 24) begin
        addr = {addr[14:0], mosi_in};
      end
    end
  end

  // Trailing edge: load next byte and step address
  always @(negedge sck_in) begin
    if (!sel_n_in && cnt >= 24 && cnt % 8 == 0) begin
      sh = addr[7:0] ^ 8'hA5;
      addr++;
    end else if (!sel_n_in) begin
      sh = {sh[6:0], 1'b0};
    end
  end

  // Deselected line shows the inverse, never a stale copy
  assign miso_out = sel_n_in ? ~sh[7] : sh[7];
endmodule // sme_mem_model

// ### sim/testbench.sv
/*
  Self-checking bench for the serial memory reader.
  Assumes the memory model above and a 10 MHz core clock.
*/
`timescale 1ns/1ps
module testbench;
  import sme_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  sme_mode_s mode_in = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'b00};
  logic tx_enable_bit_in = 1'b0;
  logic rx_enable_bit_in = 1'b0;
  logic [2:0] irq_enable_in = 3'b010; // End flag request only
  logic tx_write_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic rx_read_in = 1'b0;
  logic tx_end_clear_in = 1'b0;
  logic read_start_in = 1'b0;
  logic manual_select_in = 1'b0;
  logic [7:0] rx_data_out;
  sme_flags_s flags_out;
  logic [2:0] event_req_out;
  logic seq_busy_out, seq_done_out, mem_select_gpio_out;
  logic hw_chip_select_pin_n_out, serial_out_pin_out, serial_in_pin_in;
  logic serial_clock_pin_out;
  logic serial_clock_pin_oe_out;
  logic sck_pin = 1'b0; // Clock at the pin in slave mode
  logic [7:0] cmd_seen;
  logic [7:0] d;
  logic [7:0] codes [6] = '{SME_CMD_READ, SME_CMD_WRITE,
    SME_MEM_WRITE_ENABLE_CMD, SME_MEM_WRITE_DISABLE_CMD,
    SME_MEM_STATUS_GET_CMD, SME_MEM_STATUS_PUT_CMD};
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  time t0;

  always #50 core_clk_in = ~core_clk_in;

  sme_master_top u_sme_master_top (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .mode_in(mode_in),
    .tx_enable_bit_in(tx_enable_bit_in), .rx_enable_bit_in(rx_enable_bit_in),
    .irq_enable_in(irq_enable_in), .tx_write_in(tx_write_in),
    .tx_data_in(tx_data_in), .rx_read_in(rx_read_in),
    .rx_data_out(rx_data_out), .tx_end_clear_in(tx_end_clear_in),
    .flags_out(flags_out), .event_req_out(event_req_out),
    .read_start_in(read_start_in), .seq_busy_out(seq_busy_out),
    .seq_done_out(seq_done_out), .manual_select_in(manual_select_in),
    .mem_select_gpio_out(mem_select_gpio_out),
    .hw_chip_select_pin_n_out(hw_chip_select_pin_n_out),
    .serial_out_pin_out(serial_out_pin_out),
    .serial_in_pin_in(serial_in_pin_in),
    .serial_clock_pin_out(serial_clock_pin_out),
    .serial_clock_pin_oe_out(serial_clock_pin_oe_out),
    .serial_clock_pin_in(sck_pin));

  sme_mem_model u_sme_mem_model (.sck_in(serial_clock_pin_out),
    .sel_n_in(mem_select_gpio_out), .mosi_in(serial_out_pin_out),
    .miso_out(serial_in_pin_in), .cmd_out(cmd_seen));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Write one byte once the hold register is free
  task automatic put(input logic [7:0] b);
    for (n = 0; n < 2000 && flags_out.tx_empty !== 1'b1; n++)
      @(negedge core_clk_in);
    tx_data_in = b;
    tx_write_in = 1'b1;
    @(negedge core_clk_in);
    tx_write_in = 1'b0;
    chk(flags_out[2:1], 2'b00);
  endtask

  // Pop one byte once it is there; a bounded wait, timeout backs it
  task automatic get(output logic [7:0] b);
    for (n = 0; n < 2000 && flags_out.rx_full !== 1'b1; n++)
      @(negedge core_clk_in);
    b = rx_data_out;
    rx_read_in = 1'b1;
    @(negedge core_clk_in);
    rx_read_in = 1'b0;
    @(negedge core_clk_in); // Strobe stays low for an edge
  endtask

  task automatic wait_end();
    for (n = 0; n < 2000 && flags_out.tx_end !== 1'b1; n++)
      @(negedge core_clk_in);
    repeat (2) @(negedge core_clk_in); // Let rx_full land
  endtask

  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, far above the thousand or so cycles needed
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge core_clk_in);
    reset_in = 1'b0;
    @(negedge core_clk_in);
    chk(flags_out, 3'b100);
    chk(mem_select_gpio_out, 1'b1);
    // Enables off: a written byte must wait, not go out
    manual_select_in = 1'b1;
    put(8'h00);
    repeat (40) @(negedge core_clk_in);
    chk(hw_chip_select_pin_n_out, 1'b1);
    tx_enable_bit_in = 1'b1;
    rx_enable_bit_in = 1'b1;
    // Serial clock period in core cycles
    @(posedge serial_clock_pin_out);
    t0 = $time;
    @(posedge serial_clock_pin_out);
    chk(16'(($time - t0) / 100), 16'd4);
    chk(hw_chip_select_pin_n_out, 1'b0);
    chk(serial_clock_pin_oe_out, 1'b1);
    wait_end();
    get(d);
    // Every instruction code, each in its own selection
    foreach (codes[i]) begin
      manual_select_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
      manual_select_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      put(codes[i]);
      wait_end();
      chk(flags_out, 3'b111);
      chk(event_req_out, 3'b010);
      chk(cmd_seen, codes[i]);
      get(d);
      chk(flags_out.rx_full, 1'b0);
    end
    manual_select_in = 1'b0;
    tx_end_clear_in = 1'b1;
    @(negedge core_clk_in);
    tx_end_clear_in = 1'b0;
    chk(flags_out.tx_end, 1'b0);
    // Sequenced read with a long stall on the receive side
    read_start_in = 1'b1;
    @(negedge core_clk_in);
    read_start_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    chk(mem_select_gpio_out, 1'b0);
    chk(seq_busy_out, 1'b1);
    repeat (300) @(negedge core_clk_in);
    for (int i = 0; i < SME_READ_COUNT; i++) begin
      get(d);
      chk(d, (SME_START_ADDR[7:0] + 8'(i)) ^ 8'hA5);
    end
    chk(cmd_seen, SME_CMD_READ);
    for (n = 0; n < 500 && seq_done_out !== 1'b1; n++)
      @(negedge core_clk_in);
    chk(seq_done_out, 1'b1);
    chk(mem_select_gpio_out, 1'b1);
    chk(seq_busy_out, 1'b0);
    // Slave: sixteen pin clock edges make one frame
    mode_in.master = 1'b0;
    put(8'h5A);
    repeat (16) begin
      repeat (4) @(negedge core_clk_in);
      sck_pin = ~sck_pin;
    end
    repeat (6) @(negedge core_clk_in);
    chk(flags_out.tx_end, 1'b1);
    chk(serial_clock_pin_oe_out, 1'b0);
    tally_and_finish();
  end
endmodule // testbench
